//--- verilog/status_pkg.sv
// Shared types, register map, command counts and timing constants.
package status_pkg;

    typedef enum logic [1:0] {
        LED_OFF = 2'h0,
        LED_GREEN = 2'h1,
        LED_ORANGE = 2'h2,
        LED_RED = 2'h3
    } led_colour_t;

    typedef struct packed {
        led_colour_t system;
        led_colour_t payload;
        led_colour_t rf_link;
        led_colour_t io_link;
    } front_panel_t;

    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef enum logic [3:0] {
        PR_IDLE = 4'b0001,
        PR_DRIVE = 4'b0010,
        PR_HANDOVER = 4'b0100,
        PR_STANDBY = 4'b1000
    } prot_state_t;

    // Register offsets and control fields.
    localparam logic [ADDR_W-1:0] CTRL_OFS = 4'h0;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 4'h4;
    localparam int THR_LSB = 0;
    localparam int THR_W = 7;
    localparam int TRIB_LSB = 8;
    localparam int TRIB_MAX = 8;
    localparam int PROT_EN_BIT = 16;
    localparam logic [THR_W-1:0] THR_DEFAULT = 7'h1e;
    localparam logic [TRIB_MAX-1:0] TRIB_EN_DEFAULT = 8'hff;
    localparam logic [THR_W-1:0] PCT_FULL = 7'h64;

    // Button hold counts and the pattern that shows them.
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] BTN_CLR_HIST = 5'h01;
    localparam logic [CNT_W-1:0] BTN_CLR_LOG = 5'h02;
    localparam logic [CNT_W-1:0] BTN_FAR = 5'h07;
    localparam logic [CNT_W-1:0] BTN_NEAR = 5'h08;
    localparam logic [CNT_W-1:0] BTN_E1 = 5'h0c;
    localparam logic [CNT_W-1:0] BTN_T1 = 5'h0d;
    localparam logic [CNT_W-1:0] BTN_ALL_OFF = 5'h10;
    localparam logic [1:0] PAT_LAST = 2'h2;

    // Timing, in the unit named by each constant.
    localparam int CLK_PERIOD_NS = 10;
    localparam int ONE_SEC_NS = 1000000000;
    localparam int SEC_CYCLES = ONE_SEC_NS / CLK_PERIOD_NS;
    localparam logic [3:0] BAD_SECONDS = 4'ha;
    localparam logic [3:0] OUTAGE_LIMIT_S = 4'ha;
    localparam logic [3:0] HANDOVER_WAIT_S = 4'h5;

endpackage

//--- verilog/status_supervisor.sv
// Front-panel status, reset-button commands and 1+1 protection control.
//
// The placing of the registers and strobed register access are this design's own decisions.
module status_supervisor #(
    parameter int N_TRIB = 8,
    parameter int PKT_W = 24,
    parameter int SEC_CYC = status_pkg::SEC_CYCLES,
    parameter int STEP_CYC = status_pkg::SEC_CYCLES
) (
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    input wire status_pkg::reg_req_t reg_req_in,
    output logic [status_pkg::DATA_W-1:0] reg_rdata_out,
    input wire logic odu_comm_lost_in,
    input wire logic odu_comm_err_in,
    input wire logic trib_bit_err_in,
    input wire logic fec_correcting_in,
    input wire logic [N_TRIB-1:0] trib_los_in,
    input wire logic [N_TRIB-1:0] trib_ais_in,
    input wire logic reset_button_n_in,
    input wire logic link_configured_in,
    input wire logic frame_lock_in,
    input wire logic pkt_rx_in,
    input wire logic pkt_err_in,
    input wire logic peer_driving_in,
    input wire logic peer_lock_in,
    output status_pkg::front_panel_t panel_out,
    output logic trib_drive_out,
    output logic drive_flag_out,
    output logic lock_flag_out,
    output logic payload_t1_out,
    output logic role_near_out,
    output logic clear_log_out,
    output logic factory_default_out
);
    import status_pkg::*;

    logic [2:0] sync0_r;
    logic [2:0] sync1_r;
    logic [2:0] sync2_r;
    logic [2:0] stable_r;
    logic button_down;
    logic peer_drv;
    logic peer_lk;
    logic [31:0] sec_cnt_r;
    logic sec_tick_r;
    logic blink_r;
    logic [31:0] step_cnt_r;
    logic held_r;
    logic [CNT_W-1:0] count_r;
    logic [1:0] pat_pos_r;
    logic [1:0] pat_grp_r;
    logic release_evt;
    logic clr_hist_r;
    logic [THR_W-1:0] thr;
    logic [N_TRIB-1:0] trib_en;
    logic prot_en;
    logic [DATA_W-1:0] ctrl_r;
    logic [DATA_W-1:0] ctrl_nxt;
    logic los_now;
    logic ais_now;
    logic [5:0] now_v;
    logic [5:0] hist_r;
    front_panel_t panel_nxt;
    logic [PKT_W-1:0] pkt_cnt_r;
    logic [PKT_W-1:0] err_cnt_r;
    logic [39:0] err_scaled;
    logic [39:0] pkt_scaled;
    logic [3:0] bad_run_r;
    logic [3:0] wait_s_r;
    prot_state_t state_r;
    prot_state_t state_nxt;

    function automatic led_colour_t pick(input logic red, input logic orange,
        input logic red_h, input logic orange_h, input logic blink);
        led_colour_t c;
        c = LED_GREEN;
        if (red) begin
            c = LED_RED;
        end else if (orange) begin
            c = LED_ORANGE;
        end else if (red_h) begin
            c = blink ? LED_RED : LED_OFF;
        end else if (orange_h) begin
            c = blink ? LED_ORANGE : LED_OFF;
        end
        return c;
    endfunction

    // Button and peer pins come from outside; only stages two and three vote.
    always_ff @(posedge ref_clk_in) begin
        if (!nrst_in) begin
            sync0_r <= 3'h1;
            sync1_r <= 3'h1;
            sync2_r <= 3'h1;
            stable_r <= 3'h1;
        end else begin
            sync0_r <= {peer_lock_in, peer_driving_in, reset_button_n_in};
            sync1_r <= sync0_r;
            sync2_r <= sync1_r;
            for (int i = 0; i < 3; i++) begin
                if (sync1_r[i] == sync2_r[i]) begin
                    stable_r[i] <= sync2_r[i];
                end
            end
        end
    end

    assign button_down = !stable_r[0];
    assign peer_drv = stable_r[1];
    assign peer_lk = stable_r[2];

    always_ff @(posedge ref_clk_in) begin
        if (!nrst_in) begin
            sec_cnt_r <= 32'h0;
            sec_tick_r <= 1'b0;
            blink_r <= 1'b0;
        end else begin
            sec_tick_r <= (sec_cnt_r == 32'(SEC_CYC - 1));
            sec_cnt_r <= (sec_cnt_r == 32'(SEC_CYC - 1)) ? 32'h0
                                                         : sec_cnt_r + 32'h1;
            if (sec_tick_r) begin
                blink_r <= !blink_r;
            end
        end
    end

    // Hold counter: one step per STEP_CYC, pattern walks right to left.
    assign release_evt = held_r && !button_down;

    always_ff @(posedge ref_clk_in) begin
        if (!nrst_in) begin
            held_r <= 1'b0;
            count_r <= '0;
            step_cnt_r <= 32'h0;
            pat_pos_r <= 2'h0;
            pat_grp_r <= 2'h0;
        end else if (!held_r) begin
            if (button_down) begin
                held_r <= 1'b1;
                count_r <= BTN_CLR_HIST;
                step_cnt_r <= 32'h0;
                pat_pos_r <= 2'h0;
                pat_grp_r <= 2'h0;
            end
        end else if (!button_down) begin
            held_r <= 1'b0;
        end else if (count_r != BTN_ALL_OFF) begin
            if (step_cnt_r == 32'(STEP_CYC - 1)) begin
                step_cnt_r <= 32'h0;
                count_r <= count_r + 5'h01;
                if (pat_pos_r == PAT_LAST) begin
                    pat_pos_r <= 2'h0;
                    pat_grp_r <= (pat_grp_r == PAT_LAST) ? 2'h0
                                                         : pat_grp_r + 2'h1;
                end else begin
                    pat_pos_r <= pat_pos_r + 2'h1;
                end
            end else begin
                step_cnt_r <= step_cnt_r + 32'h1;
            end
        end
    end

    // Commands act on the release; an overshoot past the table does nothing.
    always_ff @(posedge ref_clk_in) begin
        if (!nrst_in) begin
            clr_hist_r <= 1'b0;
            clear_log_out <= 1'b0;
            factory_default_out <= 1'b0;
            payload_t1_out <= 1'b0;
            role_near_out <= 1'b1;
        end else begin
            clr_hist_r <= release_evt && count_r == BTN_CLR_HIST;
            clear_log_out <= release_evt && count_r == BTN_CLR_LOG;
            factory_default_out <= release_evt
                && (count_r == BTN_NEAR || count_r == BTN_FAR);
            if (release_evt && count_r == BTN_NEAR) begin
                role_near_out <= 1'b1;
            end else if (release_evt && count_r == BTN_FAR) begin
                role_near_out <= 1'b0;
            end
            if (release_evt && count_r == BTN_E1) begin
                payload_t1_out <= 1'b0;
            end else if (release_evt && count_r == BTN_T1) begin
                payload_t1_out <= 1'b1;
            end
        end
    end

    // Register file; a factory default wins over a write in the same cycle.
    assign thr = ctrl_r[THR_LSB +: THR_W];
    assign trib_en = ctrl_r[TRIB_LSB +: N_TRIB];
    assign prot_en = ctrl_r[PROT_EN_BIT];

    always_comb begin
        ctrl_nxt = ctrl_r;
        if (reg_req_in.wr && reg_req_in.addr == CTRL_OFS) begin
            ctrl_nxt = '0;
            ctrl_nxt[THR_LSB +: THR_W] = reg_req_in.wdata[THR_LSB +: THR_W];
            ctrl_nxt[TRIB_LSB +: N_TRIB] = reg_req_in.wdata[TRIB_LSB +: N_TRIB];
            ctrl_nxt[PROT_EN_BIT] = reg_req_in.wdata[PROT_EN_BIT];
        end
        if (factory_default_out) begin
            ctrl_nxt = '0;
            ctrl_nxt[THR_LSB +: THR_W] = THR_DEFAULT;
            ctrl_nxt[TRIB_LSB +: N_TRIB] = TRIB_EN_DEFAULT[N_TRIB-1:0];
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!nrst_in) begin
            ctrl_r <= '0;
            ctrl_r[THR_LSB +: THR_W] <= THR_DEFAULT;
            ctrl_r[TRIB_LSB +: N_TRIB] <= TRIB_EN_DEFAULT[N_TRIB-1:0];
        end else begin
            ctrl_r <= ctrl_nxt;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!nrst_in) begin
            reg_rdata_out <= '0;
        end else if (reg_req_in.rd && reg_req_in.addr == CTRL_OFS) begin
            reg_rdata_out <= ctrl_r;
        end else if (reg_req_in.rd && reg_req_in.addr == STATUS_OFS) begin
            reg_rdata_out <= {16'h0, bad_run_r, state_r, 2'h0, hist_r};
        end else begin
            reg_rdata_out <= '0;
        end
    end

    // Present conditions: sys red, sys orange, rf red, rf orange, pay red/orange.
    assign los_now = |(trib_los_in & trib_en);
    assign ais_now = |(trib_ais_in & trib_en);
    assign now_v = {ais_now, los_now, fec_correcting_in, trib_bit_err_in,
                    odu_comm_err_in, odu_comm_lost_in};

    // A condition present in the clear cycle survives, so no event is lost.
    always_ff @(posedge ref_clk_in) begin
        if (!nrst_in) begin
            hist_r <= 6'h0;
        end else begin
            hist_r <= (clr_hist_r ? 6'h0 : hist_r) | now_v;
        end
    end

    always_comb begin
        panel_nxt.system = pick(now_v[0], now_v[1], hist_r[0], hist_r[1],
                                blink_r);
        panel_nxt.rf_link = pick(now_v[2], now_v[3], hist_r[2], hist_r[3],
                                 blink_r);
        panel_nxt.payload = pick(now_v[4], now_v[5], hist_r[4], hist_r[5],
                                 blink_r);
        panel_nxt.io_link = odu_comm_lost_in ? LED_OFF : LED_GREEN;
        if (held_r) begin
            panel_nxt.system = LED_OFF;
            panel_nxt.payload = LED_OFF;
            panel_nxt.rf_link = LED_OFF;
            if (count_r != BTN_ALL_OFF) begin
                case (pat_pos_r)
                    2'h0: panel_nxt.rf_link = led_colour_t'(pat_grp_r + 2'h1);
                    2'h1: panel_nxt.payload = led_colour_t'(pat_grp_r + 2'h1);
                    default: panel_nxt.system = led_colour_t'(pat_grp_r + 2'h1);
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!nrst_in) begin
            panel_out <= '0;
        end else begin
            panel_out <= panel_nxt;
        end
    end

    // Packet error ratio per second, compared as err*100 > thr*packets.
    assign err_scaled = (40'(err_cnt_r)) * (40'(PCT_FULL));
    assign pkt_scaled = (40'(pkt_cnt_r)) * (40'(thr));

    always_ff @(posedge ref_clk_in) begin
        if (!nrst_in) begin
            pkt_cnt_r <= '0;
            err_cnt_r <= '0;
            bad_run_r <= 4'h0;
        end else if (sec_tick_r) begin
            pkt_cnt_r <= '0;
            err_cnt_r <= '0;
            if (pkt_cnt_r != '0 && err_scaled > pkt_scaled) begin
                if (bad_run_r != BAD_SECONDS) begin
                    bad_run_r <= bad_run_r + 4'h1;
                end
            end else begin
                bad_run_r <= 4'h0;
            end
        end else begin
            if (pkt_rx_in && pkt_cnt_r != '1) begin
                pkt_cnt_r <= pkt_cnt_r + 1'b1;
            end
            if (pkt_err_in && err_cnt_r != '1) begin
                err_cnt_r <= err_cnt_r + 1'b1;
            end
        end
    end

    // Protection: dropping the driving flag is the takeover request.
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            PR_IDLE: begin
                if (peer_drv) begin
                    state_nxt = PR_STANDBY;
                end else if (link_configured_in) begin
                    state_nxt = PR_DRIVE;
                end
            end
            PR_DRIVE: begin
                if (prot_en && bad_run_r == BAD_SECONDS && peer_lk) begin
                    state_nxt = PR_HANDOVER;
                end
            end
            PR_HANDOVER: begin
                if (peer_drv) begin
                    state_nxt = PR_STANDBY;
                end else if (wait_s_r == HANDOVER_WAIT_S) begin
                    state_nxt = PR_DRIVE;
                end
            end
            PR_STANDBY: begin
                if (!peer_drv && link_configured_in && frame_lock_in) begin
                    state_nxt = PR_DRIVE;
                end
            end
            default: state_nxt = PR_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (!nrst_in) begin
            state_r <= PR_IDLE;
            wait_s_r <= 4'h0;
        end else begin
            state_r <= state_nxt;
            if (state_nxt != PR_HANDOVER) begin
                wait_s_r <= 4'h0;
            end else if (sec_tick_r) begin
                wait_s_r <= wait_s_r + 4'h1;
            end
        end
    end

    // Only tributary drive is switched; Ethernet paths never see this state.
    always_ff @(posedge ref_clk_in) begin
        if (!nrst_in) begin
            trib_drive_out <= 1'b0;
            drive_flag_out <= 1'b0;
            lock_flag_out <= 1'b0;
        end else begin
            trib_drive_out <= (state_nxt == PR_DRIVE);
            drive_flag_out <= (state_nxt == PR_DRIVE);
            lock_flag_out <= frame_lock_in;
        end
    end

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!nrst_in);

    sequence s_release(logic [CNT_W-1:0] n);
        held_r && !button_down && count_r == n;
    endsequence

    a_sys_red_fault: assert property (
        odu_comm_lost_in && !held_r |=> panel_out.system == LED_RED)
        else $error("system indicator not red on lost link");
    a_rf_red_err: assert property (
        trib_bit_err_in && !held_r |=> panel_out.rf_link == LED_RED)
        else $error("radio indicator not red on bit errors");
    a_rf_orange_fec: assert property (
        fec_correcting_in && !trib_bit_err_in && !held_r
        |=> panel_out.rf_link == LED_ORANGE)
        else $error("radio indicator not orange on correction");
    a_pay_los_mask: assert property (
        !held_r && !(|(trib_los_in & trib_en)) && !hist_r[4]
        |=> panel_out.payload != LED_RED)
        else $error("inactive tributary raised payload red");
    a_hist_blink_on: assert property (
        !held_r && now_v == 6'h0 && hist_r[0] && !clr_hist_r
        |=> panel_out.system inside {LED_RED, LED_OFF})
        else $error("past system error not blinking red");
    a_hist_cleared: assert property (
        s_release(BTN_CLR_HIST) ##1 now_v == 6'h0 |=> hist_r == 6'h0)
        else $error("history not cleared after count one");
    a_log_clear: assert property (
        s_release(BTN_CLR_LOG) |=> clear_log_out ##1 !clear_log_out)
        else $error("event log clear not a single pulse");
    a_t1_select: assert property (
        s_release(BTN_T1) |=> payload_t1_out)
        else $error("T1 not selected at count thirteen");
    a_far_default: assert property (
        s_release(BTN_FAR) |=> factory_default_out && !role_near_out
        ##1 ctrl_r[THR_LSB +: THR_W] == THR_DEFAULT)
        else $error("far default not restored");
    a_io_led_off: assert property (
        odu_comm_lost_in |=> panel_out.io_link == LED_OFF)
        else $error("link indicator lit without communication");
    a_no_lock_hold: assert property (
        state_r == PR_DRIVE && !peer_lk |=> state_r == PR_DRIVE)
        else $error("drive dropped while peer has no lock");
    a_outage_bound: assert property (
        state_r == PR_HANDOVER |-> wait_s_r <= HANDOVER_WAIT_S
        && HANDOVER_WAIT_S < OUTAGE_LIMIT_S)
        else $error("handover wait beyond outage limit");
    a_drive_flag_tie: assert property (
        trib_drive_out == drive_flag_out
        && $past(trib_drive_out) == ($past(state_r) == PR_DRIVE))
        else $error("drive flag disagrees with tributary drive");

endmodule // status_supervisor

//--- bench/peer_unit.sv
// Behavioural model of the peer indoor unit on the status cable.
module peer_unit (
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    input wire logic drive_flag_in,
    input wire logic lock_en_in,
    input wire logic fail_in,
    output logic peer_driving_out,
    output logic peer_lock_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // Armed only once the unit has been seen driving, so idle is no request.
    logic armed_r;
    always_ff @(posedge ref_clk_in) begin
        if (!nrst_in) begin
            armed_r <= 1'b0;
            peer_driving_out <= 1'b0;
            peer_lock_out <= 1'b0;
        end else begin
            armed_r <= armed_r | drive_flag_in;
            peer_lock_out <= lock_en_in & ~fail_in;
            if (fail_in)
                peer_driving_out <= 1'b0;
            else if (armed_r & ~drive_flag_in & peer_lock_out)
                peer_driving_out <= 1'b1;
        end
    end
endmodule // peer_unit

//--- bench/testbench.sv
// Self-checking bench for the supervisor with a peer unit model.
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import status_pkg::*;
    localparam int S = 20;
    logic clk, nrst, lost, cerr, berr, fec, btn_n, cfg, lock, prx, perr;
    logic peer_drv, peer_lk, drive, dflag, lflag, t1, near, clog, fac;
    logic lock_en, fail;
    logic [7:0] los, ais, en;
    logic [31:0] rdata, d, rnd;
    reg_req_t req;
    front_panel_t panel;
    int err_count = 0, n_compared = 0, nlog = 0, nfac = 0, both = 0;
    int b, nr, no;
    status_supervisor #(.SEC_CYC(S), .STEP_CYC(S)) uut (
        .ref_clk_in(clk), .nrst_in(nrst), .reg_req_in(req),
        .reg_rdata_out(rdata), .odu_comm_lost_in(lost),
        .odu_comm_err_in(cerr), .trib_bit_err_in(berr),
        .fec_correcting_in(fec), .trib_los_in(los), .trib_ais_in(ais),
        .reset_button_n_in(btn_n), .link_configured_in(cfg),
        .frame_lock_in(lock), .pkt_rx_in(prx), .pkt_err_in(perr),
        .peer_driving_in(peer_drv), .peer_lock_in(peer_lk),
        .panel_out(panel), .trib_drive_out(drive), .drive_flag_out(dflag),
        .lock_flag_out(lflag), .payload_t1_out(t1), .role_near_out(near),
        .clear_log_out(clog), .factory_default_out(fac));
    peer_unit peer (.ref_clk_in(clk), .nrst_in(nrst),
        .drive_flag_in(dflag), .lock_en_in(lock_en), .fail_in(fail),
        .peer_driving_out(peer_drv), .peer_lock_out(peer_lk));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (clog === 1'b1) nlog++;
        if (fac === 1'b1) nfac++;
        if (drive === 1'b1 && peer_drv === 1'b1) both++;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Position of the button pattern: right, middle, left.
    function automatic logic [31:0] pat(input int k);
        case ((k - 1) % 3)
            0: return {30'h0, panel.rf_link};
            1: return {30'h0, panel.payload};
            default: return {30'h0, panel.system};
        endcase
    endfunction
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        cyc(1);
        req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        cyc(1);
        req.rd <= 1'b0;
        #1 v = rdata;
        cyc(1);
    endtask
    task automatic press(input int k);
        btn_n <= 1'b0;
        cyc(4 + (k - 1) * S + S / 2);
        chk(pat(k), ((k - 1) / 3) % 3 + 1);
        btn_n <= 1'b1;
        cyc(12);
    endtask
    task automatic hold(input int n, output int bad);
        bad = 0;
        repeat (n) begin
            cyc(1);
            if (drive !== 1'b1) bad++;
        end
    endtask
    task automatic wait_drive(input logic v, input int n);
        for (int i = 0; i < n && drive !== v; i++) cyc(1);
        chk(drive, v);
        if (drive !== v) final_report();
    endtask
    initial begin
        req = '0;
        {nrst, lost, cerr, berr, fec, cfg, lock, prx, perr} = '0;
        {lock_en, fail, los, ais} = '0;
        btn_n = 1'b1;
        rnd = lfsr(32'h9b930276);
        cyc(10);
        nrst <= 1'b1;
        cyc(1);
        chk(panel, 0);
        chk({drive, near, t1}, 3'h2);
        rd(CTRL_OFS, d);
        chk(d, 32'h0000ff1e);
        rd(4'h8, d);
        chk(d, 32'h0);
        en = ~(8'h01 << rnd[2:0]);
        wr(CTRL_OFS, {16'h0, en, 8'h1e});
        los <= ~en;
        cyc(3);
        chk(panel.payload, LED_GREEN);
        wr(CTRL_OFS, 32'h0000ff1e);
        cyc(3);
        chk(panel.payload, LED_RED);
        los <= 8'h0;
        lost <= 1'b1;
        fec <= 1'b1;
        cyc(3);
        chk(panel.system, LED_RED);
        chk(panel.io_link, LED_OFF);
        chk(panel.rf_link, LED_ORANGE);
        {lost, cerr, berr, ais} <= {3'h3, 8'h10};
        cyc(3);
        chk(panel.system, LED_ORANGE);
        chk(panel.rf_link, LED_RED);
        chk(panel.payload, LED_ORANGE);
        {cerr, berr, fec, ais} <= '0;
        nr = 0;
        no = 0;
        repeat (3 * S) begin
            cyc(1);
            if (panel.system === LED_RED) nr++;
            if (panel.system === LED_OFF) no++;
        end
        chk(nr > 0 && no > 0, 1);
        press(1);
        chk(panel.system, LED_GREEN);
        press(2);
        chk(nlog, 1);
        press(13);
        chk(t1, 1);
        press(12);
        chk(t1, 0);
        wr(CTRL_OFS, 32'h0);
        press(7);
        chk({near, 4'(nfac)}, 5'h01);
        rd(CTRL_OFS, d);
        chk(d, 32'h0000ff1e);
        press(8);
        chk({near, 4'(nfac)}, 5'h12);
        press(3);
        chk({4'(nlog), 4'(nfac)}, 8'h12);
        cfg <= 1'b1;
        lock <= 1'b1;
        cyc(4);
        chk({drive, dflag, lflag}, 3'h7);
        rd(STATUS_OFS, d);
        chk(d[11:8], 4'h2);
        wr(CTRL_OFS, 32'h0001ff64);
        {prx, perr, lock_en} <= 3'h7;
        hold(12 * S, b);
        chk(b, 0);
        lock_en <= 1'b0;
        wr(CTRL_OFS, 32'h0001ff1e);
        hold(12 * S, b);
        chk(b, 0);
        lock_en <= 1'b1;
        wait_drive(1'b0, 11 * S);
        cyc(8);
        chk(peer_drv, 1);
        {prx, perr, fail} <= 3'h1;
        wait_drive(1'b1, 10 * S);
        chk(both, 0);
        final_report();
    end
endmodule // testbench
